// *** shared/encoder_pkg.sv ***
// package: register map, field layout, mode codes and pin carrier of the encoder core
package encoder_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] OPT_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] POS_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] TMR_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] VEL_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] INIT_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] GEC_OFF = 8'h1C;
  localparam logic [ADDR_W-1:0] LEC_OFF = 8'h20;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h24;
  // control field positions
  localparam int EN_BIT = 15;
  localparam int SIDL_BIT = 13;
  localparam int PIM_LSB = 10;
  localparam int IMV_LSB = 8;
  localparam int DIV_LSB = 4;
  localparam int POL_BIT = 3;
  localparam int GATE_BIT = 2;
  localparam int CCM_LSB = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hBF7F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // option field positions
  localparam int SWAP_BIT = 0;
  localparam int POLA_BIT = 1;
  localparam int POLB_BIT = 2;
  localparam int POLI_BIT = 3;
  localparam logic [3:0] OPT_RESET = 4'h0;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [15:0] VEL_RESET = 16'h0000;
  // position initialisation modes
  localparam logic [2:0] PIM_NONE = 3'h0;
  localparam logic [2:0] PIM_RESET = 3'h1;
  localparam logic [2:0] PIM_NEXT = 3'h2;
  localparam logic [2:0] PIM_HOME1 = 3'h3;
  localparam logic [2:0] PIM_HOME2 = 3'h4;
  localparam logic [2:0] PIM_GEC = 3'h5;
  localparam logic [2:0] PIM_MODULO = 3'h6;
  // count modes
  localparam logic [1:0] CCM_QUAD = 2'h0;
  localparam logic [1:0] CCM_UPDN = 2'h1;
  localparam logic [1:0] CCM_GTMR = 2'h2;
  localparam logic [1:0] CCM_ITMR = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // encoder pins as sampled at the block edge
  typedef struct packed {
    logic home;
    logic index;
    logic phase_b;
    logic phase_a;
  } enc_pins_t;
endpackage

// *** src/encoder_interface.sv ***
// encoder interface core: quadrature decode, counters and axi4-lite register slave
//
// Behaviour
// R1: enable bit runs counters, registers stay accessible
// R2: stop-in-idle halts counting during device idle
// R3: mode 000 ignores index, 001 resets
// R4: mode 010 loads init on next index
// R5: mode 011 loads on first index after home
// R6: mode 100 loads on second index after home
// R7: mode 101 resets position at compare equality
// R8: mode 110 counts modulo; 111 reserved
// R9: match bits give required phase B, A
// R10: match uses swapped, inverted phase signals
// R11: timer count modes ignore initialisation mode
// R12: quadrature mode index needs phase match
// R13: software picks divider above twice count rate
// R14: counters 32 bits, velocity 16 bits
// R15: init/high compare and low compare registers
// R16: five counting modes supported; the code has four: x4 quadrature, up/down, gated timer, timer
// R17: control bits 14, 7 read zero
// R18: x4 steps on every phase edge
// R19: control resets to zero, counters disabled
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module encoder_interface
  import encoder_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // device state and encoder pins
  input wire logic idle_mode,
  input wire enc_pins_t pins,
  output logic compare_out,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [15:0] ctrl_q;
  logic [3:0] opt_q;
  logic [31:0] pos_q, idx_q, tmr_q, init_q, gec_q, lec_q;
  logic [15:0] vel_q;
  logic [3:0] pins_q;
  logic [7:0] pre_q;
  logic arm_q;
  logic [1:0] seen_q;
  logic aw_got_q, w_got_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // control fields
  logic [2:0] pim;
  logic [1:0] index_match_value, count_mode_field;
  logic [2:0] div;
  logic run, timer_mode;
  assign pim = ctrl_q[PIM_LSB +: 3];
  assign index_match_value = ctrl_q[IMV_LSB +: 2];
  assign div = ctrl_q[DIV_LSB +: 3];
  assign count_mode_field = ctrl_q[CCM_LSB +: 2];
  assign run = ctrl_q[EN_BIT] && !(ctrl_q[SIDL_BIT] && idle_mode); // R1 R2
  assign timer_mode = count_mode_field == CCM_GTMR || count_mode_field == CCM_ITMR; // R11

  // conditioned inputs: swap then invert
  logic a_c, b_c, i_c, h_c;
  logic pa, pb, pi, ph;
  assign a_c = (opt_q[SWAP_BIT] ? pins.phase_b : pins.phase_a) ^ opt_q[POLA_BIT]; // R10
  assign b_c = (opt_q[SWAP_BIT] ? pins.phase_a : pins.phase_b) ^ opt_q[POLB_BIT]; // R10
  assign i_c = pins.index ^ opt_q[POLI_BIT];
  assign h_c = pins.home;
  assign {ph, pi, pb, pa} = pins_q;

  // previous levels for edge detection; inputs are already synchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_q <= 4'h0;
    end else if (clk_en) begin
      pins_q <= {h_c, i_c, b_c, a_c};
    end
  end

  // step and direction per count mode
  logic step, up, quad_step, gate_ok;
  assign quad_step = (a_c ^ pa) ^ (b_c ^ pb); // R18
  assign gate_ok = !ctrl_q[GATE_BIT] || i_c;
  always_comb begin
    step = 1'b0;
    up = 1'b0;
    unique case (count_mode_field)
      CCM_QUAD: begin
        step = quad_step; // R16 R18
        up = (a_c ^ pb) ^ ctrl_q[POL_BIT];
      end
      CCM_UPDN: begin
        step = a_c && !pa && gate_ok; // R16
        up = b_c ^ ctrl_q[POL_BIT];
      end
      CCM_GTMR, CCM_ITMR: begin
        step = 1'b0;
        up = 1'b1;
      end
    endcase
  end

  // index event, gated by phase match in quadrature mode
  logic idx_rise, match, idx_event, home_rise;
  assign idx_rise = i_c && !pi;
  assign match = b_c == index_match_value[1] && a_c == index_match_value[0]; // R9
  assign idx_event = idx_rise && (count_mode_field != CCM_QUAD || match); // R12
  assign home_rise = h_c && !ph;

  // timer tick from divided clock; divider must beat twice the count rate
  logic [7:0] div_mask;
  logic tick;
  assign div_mask = 8'((9'h001 << div) - 9'h001); // R13
  assign tick = (pre_q & div_mask) == div_mask;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 8'h00;
    end else if (clk_en) begin
      pre_q <= run ? pre_q + 8'h01 : 8'h00;
    end
  end

  // axi write: address and data accepted in either order
  logic wr_fire;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
    end
  end

  logic wr_ctrl, wr_opt, wr_pos, wr_idx, wr_tmr, wr_vel, wr_init, wr_gec, wr_lec, wr_ok;
  assign wr_ctrl = wr_fire && waddr_q == CTRL_OFF;
  assign wr_opt = wr_fire && waddr_q == OPT_OFF;
  assign wr_pos = wr_fire && waddr_q == POS_OFF;
  assign wr_idx = wr_fire && waddr_q == IDX_OFF;
  assign wr_tmr = wr_fire && waddr_q == TMR_OFF;
  assign wr_vel = wr_fire && waddr_q == VEL_OFF;
  assign wr_init = wr_fire && waddr_q == INIT_OFF;
  assign wr_gec = wr_fire && waddr_q == GEC_OFF;
  assign wr_lec = wr_fire && waddr_q == LEC_OFF;
  assign wr_ok = wr_ctrl | wr_opt | wr_pos | wr_idx | wr_tmr | wr_vel | wr_init | wr_gec
                 | wr_lec | (waddr_q == STAT_OFF);

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; counters stay writable while disabled
  logic [31:0] ctrl_m;
  assign ctrl_m = merge({16'h0000, ctrl_q}, wdata_q, wstrb_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET; // R19
      opt_q <= OPT_RESET;
      init_q <= CNT_RESET;
      gec_q <= CNT_RESET;
      lec_q <= CNT_RESET;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_m[15:0] & CTRL_WMASK; // R1 R17
      end
      if (wr_opt) begin
        opt_q <= 4'(merge({28'h0, opt_q}, wdata_q, wstrb_q));
      end
      if (wr_init) begin
        init_q <= merge(init_q, wdata_q, wstrb_q); // R15
      end
      if (wr_gec) begin
        gec_q <= merge(gec_q, wdata_q, wstrb_q); // R15
      end
      if (wr_lec) begin
        lec_q <= merge(lec_q, wdata_q, wstrb_q); // R15
      end
    end
  end

  // index-load arming: next index after control write, or home-relative
  logic load_now;
  always_comb begin
    unique case (pim)
      PIM_NEXT: load_now = arm_q; // R4
      PIM_HOME1: load_now = arm_q && seen_q == 2'd0; // R5
      PIM_HOME2: load_now = arm_q && seen_q == 2'd1; // R6
      default: load_now = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_q <= 1'b0;
      seen_q <= 2'd0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        // only mode 010 arms on a write; home modes must wait for a home edge
        arm_q <= ctrl_m[PIM_LSB +: 3] == PIM_NEXT; // R4 R5 R6
        seen_q <= 2'd0;
      end else if (home_rise && run && (pim == PIM_HOME1 || pim == PIM_HOME2)) begin
        arm_q <= 1'b1; // R5 R6
        seen_q <= 2'd0;
      end else if (run && idx_event && !timer_mode) begin
        if (load_now) begin
          arm_q <= 1'b0;
        end else if (arm_q && seen_q != 2'd3) begin
          seen_q <= seen_q + 2'd1;
        end
      end
    end
  end

  // position counter: software write, then index, compare, step
  logic at_gec, at_lec;
  assign at_gec = pos_q == gec_q;
  assign at_lec = pos_q == lec_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q <= CNT_RESET; // R14
    end else if (clk_en) begin
      if (wr_pos) begin
        pos_q <= merge(pos_q, wdata_q, wstrb_q);
      end else if (run) begin // R1
        if (timer_mode) begin
          if (tick && (count_mode_field == CCM_ITMR || i_c)) begin
            pos_q <= pos_q + 32'h0000_0001; // R11 R16
          end
        end else if (idx_event && pim == PIM_RESET) begin
          pos_q <= CNT_RESET; // R3 R12
        end else if (idx_event && load_now) begin
          pos_q <= init_q; // R4 R5 R6
        end else if (pim == PIM_GEC && at_gec) begin
          pos_q <= CNT_RESET; // R7
        end else if (step) begin
          if (pim == PIM_MODULO && up && at_gec) begin
            pos_q <= lec_q; // R8
          end else if (pim == PIM_MODULO && !up && at_lec) begin
            pos_q <= gec_q; // R8
          end else begin
            pos_q <= up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
          end
        end
      end
    end
  end

  // index pulse counter follows direction; interval timer free-runs on ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_q <= CNT_RESET; // R14
      tmr_q <= CNT_RESET; // R14
    end else if (clk_en) begin
      if (wr_idx) begin
        idx_q <= merge(idx_q, wdata_q, wstrb_q);
      end else if (run && idx_event) begin
        idx_q <= up ? idx_q + 32'h0000_0001 : idx_q - 32'h0000_0001;
      end
      if (wr_tmr) begin
        tmr_q <= merge(tmr_q, wdata_q, wstrb_q);
      end else if (run && tick) begin
        tmr_q <= tmr_q + 32'h0000_0001;
      end
    end
  end

  // axi read; one outstanding read, answered one cycle after address
  logic rd_fire, rd_vel;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_vel = rd_fire && s_axi_araddr == VEL_OFF;

  // velocity counter clears on read; a step in that cycle survives
  logic vstep;
  logic [15:0] vel_base;
  assign vstep = run && step;
  assign vel_base = rd_vel ? VEL_RESET : vel_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vel_q <= VEL_RESET; // R14
    end else if (clk_en) begin
      if (wr_vel) begin
        vel_q <= 16'(merge({16'h0000, vel_q}, wdata_q, wstrb_q));
      end else if (vstep) begin
        vel_q <= up ? vel_base + 16'h0001 : vel_base - 16'h0001;
      end else if (rd_vel) begin
        vel_q <= VEL_RESET;
      end
    end
  end

  logic [31:0] rmux;
  logic rerr;
  always_comb begin
    rmux = 32'h0000_0000;
    rerr = 1'b0;
    unique case (s_axi_araddr)
      CTRL_OFF: rmux = {16'h0000, ctrl_q}; // R17
      OPT_OFF: rmux = {28'h000_0000, opt_q};
      POS_OFF: rmux = pos_q;
      IDX_OFF: rmux = idx_q;
      TMR_OFF: rmux = tmr_q;
      VEL_OFF: rmux = {16'h0000, vel_q};
      INIT_OFF: rmux = init_q;
      GEC_OFF: rmux = gec_q;
      LEC_OFF: rmux = lec_q;
      STAT_OFF: rmux = {26'h000_0000, seen_q, arm_q, i_c, b_c, a_c};
      default: rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux;
        s_axi_rresp <= rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // compare output: position inside the low/high window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_out <= 1'b0;
    end else if (clk_en) begin
      compare_out <= ($signed(pos_q) >= $signed(lec_q)) && ($signed(pos_q) <= $signed(gec_q));
    end
  end

endmodule

// *** testbench/encoder_interface_props.sv ***
// checker: bus timing and read-value properties of the encoder core
`timescale 1ns/1ps
module encoder_interface_props
  import encoder_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // bus signals watched
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [ADDR_W-1:0] raddr_q;
  // read address kept so data checks know what was asked
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready && clk_en) begin
      raddr_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_IDLE: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response pending after reset");
  AST_RD_NEXT: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid)
    else $error("read answer not released");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && clk_en |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid)
    else $error("write answer not released");
  AST_CTRL_ZERO: assert property (s_axi_rvalid && raddr_q == CTRL_OFF |->
    s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[14] && !s_axi_rdata[7])
    else $error("control unused bits not zero");
  AST_VEL_W: assert property (s_axi_rvalid && raddr_q == VEL_OFF |->
    s_axi_rdata[31:16] == 16'h0000)
    else $error("velocity wider than 16 bits");
endmodule
bind encoder_interface encoder_interface_props encoder_interface_props_inst (.*);

// *** testbench/encoder_interface_tb.sv ***
// testbench for the encoder core: register access and counting scenarios
`timescale 1ns/1ps
module encoder_interface_tb;
  import encoder_pkg::*;
  logic aclk, aresetn, clk_en, idle_mode, compare_out;
  enc_pins_t pins;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count = 0;
  int comparisons = 0;
  encoder_interface encoder_interface_inst (.*);
  quad_encoder_model quad_encoder_model_inst (.aclk(aclk), .pins(pins));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rdr(a, v);
    check(name, v, exp);
  endtask
  // enabled control word, divider 0 ticks every cycle, above twice the step rate
  function automatic logic [31:0] ctl(input logic [2:0] pim, input logic [1:0] index_match_value,
      input logic [1:0] count_mode_field);
    return 32'h0000_8000 | (32'(pim) << PIM_LSB) | (32'(index_match_value) << IMV_LSB) | 32'(count_mode_field);
  endfunction
  task automatic t_regs();
    rc("ctrl reset", CTRL_OFF, 32'h0000_0000);
    rc("vel reset", VEL_OFF, 32'h0000_0000);
    wr(CTRL_OFF, 32'h0000_FFFF);
    rc("ctrl mask", CTRL_OFF, 32'h0000_BF7F);
    // low lane only: upper control byte must survive
    s_axi_wstrb <= 4'h1;
    wr(CTRL_OFF, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    rc("ctrl lanes", CTRL_OFF, 32'h0000_BF00);
    wr(CTRL_OFF, 32'h0000_0000);
    wr(IDX_OFF, 32'hA5A5_5A5A);
    rc("index count", IDX_OFF, 32'hA5A5_5A5A);
    wr(LEC_OFF, 32'h8001_7FFE);
    rc("low compare", LEC_OFF, 32'h8001_7FFE);
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    rdr(8'h40, rd, RESP_SLVERR);
    check("unmapped", rd, 32'h0000_0000);
  endtask
  task automatic t_count();
    wr(POS_OFF, 32'h0000_0000);
    quad_encoder_model_inst.move(1, 4);
    rc("disabled", POS_OFF, 32'h0000_0000);
    wr(CTRL_OFF, ctl(PIM_NONE, 2'h0, CCM_QUAD));
    quad_encoder_model_inst.move(1, 8);
    quad_encoder_model_inst.move(0, 3);
    rc("x4 count", POS_OFF, 32'h0000_0005);
    rc("velocity", VEL_OFF, 32'h0000_0005);
    quad_encoder_model_inst.move(0, 7);
    rc("below zero", POS_OFF, 32'hFFFF_FFFE);
    @(posedge aclk);
    idle_mode <= 1'b1;
    quad_encoder_model_inst.move(1, 2);
    rc("idle runs", POS_OFF, 32'h0000_0000);
    wr(CTRL_OFF, ctl(PIM_NONE, 2'h0, CCM_QUAD) | 32'h0000_2000);
    quad_encoder_model_inst.move(1, 4);
    rc("idle stops", POS_OFF, 32'h0000_0000);
    @(posedge aclk);
    idle_mode <= 1'b0;
  endtask
  // phases at 00 here; swap is changed only while both phases agree
  task automatic t_index();
    wr(POS_OFF, 32'h0000_0077);
    wr(CTRL_OFF, ctl(PIM_NONE, 2'h0, CCM_QUAD));
    quad_encoder_model_inst.pulse(0);
    rc("index ignored", POS_OFF, 32'h0000_0077);
    wr(OPT_OFF, 32'h0000_0001);
    quad_encoder_model_inst.move(1, 1);
    wr(POS_OFF, 32'h0000_0077);
    wr(CTRL_OFF, ctl(PIM_RESET, 2'h1, CCM_QUAD));
    quad_encoder_model_inst.pulse(0);
    rc("swapped miss", POS_OFF, 32'h0000_0077);
    wr(CTRL_OFF, ctl(PIM_RESET, 2'h2, CCM_QUAD));
    quad_encoder_model_inst.pulse(0);
    rc("match reset", POS_OFF, 32'h0000_0000);
    quad_encoder_model_inst.move(1, 1);
    wr(OPT_OFF, 32'h0000_0000);
  endtask
  // phases at 11: match value 3 lets index events through
  task automatic t_load();
    wr(INIT_OFF, 32'h0000_1234);
    wr(POS_OFF, 32'h0000_0010);
    wr(CTRL_OFF, ctl(PIM_NEXT, 2'h3, CCM_QUAD));
    quad_encoder_model_inst.pulse(0);
    rc("next load", POS_OFF, 32'h0000_1234);
    wr(POS_OFF, 32'h0000_0010);
    quad_encoder_model_inst.pulse(0);
    rc("load once", POS_OFF, 32'h0000_0010);
    for (int k = 0; k < 2; k++) begin
      wr(CTRL_OFF, ctl(k ? PIM_HOME2 : PIM_HOME1, 2'h3, CCM_QUAD));
      quad_encoder_model_inst.pulse(0);
      rc("before home", POS_OFF, 32'h0000_0010);
      quad_encoder_model_inst.pulse(1);
      if (k) quad_encoder_model_inst.pulse(0);
      rc("first after home", POS_OFF, 32'h0000_0010);
      quad_encoder_model_inst.pulse(0);
      rc("home load", POS_OFF, 32'h0000_1234);
      wr(POS_OFF, 32'h0000_0010);
    end
  endtask
  task automatic t_cmp();
    wr(POS_OFF, 32'h0000_0020);
    wr(GEC_OFF, 32'h0000_0022);
    wr(CTRL_OFF, ctl(PIM_GEC, 2'h0, CCM_QUAD));
    quad_encoder_model_inst.move(1, 2);
    rc("compare reset", POS_OFF, 32'h0000_0000);
    wr(LEC_OFF, 32'h0000_0000);
    wr(GEC_OFF, 32'h0000_0003);
    wr(CTRL_OFF, ctl(PIM_MODULO, 2'h0, CCM_QUAD));
    quad_encoder_model_inst.move(1, 5);
    rc("modulo up", POS_OFF, 32'h0000_0001);
    quad_encoder_model_inst.move(0, 3);
    rc("modulo down", POS_OFF, 32'h0000_0002);
    check("in window", 32'(compare_out), 32'h0000_0001);
  endtask
  // a load on index would jump far above the tick count
  task automatic t_timer();
    wr(POS_OFF, 32'h0000_0000);
    wr(CTRL_OFF, ctl(PIM_NEXT, 2'h0, CCM_ITMR));
    quad_encoder_model_inst.pulse(0);
    rdr(POS_OFF, rd);
    check("timer ticks", 32'(rd != 32'h0000_0000), 32'h0000_0001);
    check("init ignored", 32'(rd < 32'h0000_0100), 32'h0000_0001);
    wr(CTRL_OFF, 32'h0000_0000);
  endtask
  // full encoder cycle while frozen leaves no net edge, then a mid-run reset
  task automatic t_freeze();
    wr(POS_OFF, 32'h0000_0040);
    wr(CTRL_OFF, ctl(PIM_NONE, 2'h0, CCM_QUAD));
    @(posedge aclk);
    clk_en <= 1'b0;
    quad_encoder_model_inst.move(1, 4);
    clk_en <= 1'b1;
    rc("frozen", POS_OFF, 32'h0000_0040);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl after reset", CTRL_OFF, 32'h0000_0000);
    rc("pos after reset", POS_OFF, 32'h0000_0000);
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    close_out();
  end
  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    idle_mode = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_count();
    t_index();
    t_load();
    t_cmp();
    t_timer();
    t_freeze();
    close_out();
  end
endmodule

// *** testbench/quad_encoder_model.sv ***
// encoder model: gray-coded phases, index and home pulses
`timescale 1ns/1ps
module quad_encoder_model
  import encoder_pkg::*;
(
  // clock
  input wire logic aclk,
  // encoder pins
  output enc_pins_t pins
);
  logic [1:0] q_q;
  initial begin
    q_q = 2'h0;
    pins = '0;
  end
  // one phase changes per step, spaced so every level is sampled
  task automatic move(input logic up, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge aclk);
      q_q = up ? q_q + 2'h1 : q_q - 2'h1;
      pins.phase_b <= q_q[1];
      pins.phase_a <= q_q[1] ^ q_q[0];
    end
    repeat (4) @(posedge aclk);
  endtask
  // home or index pulse of two cycles
  task automatic pulse(input logic home);
    @(posedge aclk);
    if (home) pins.home <= 1'b1;
    else pins.index <= 1'b1;
    repeat (2) @(posedge aclk);
    pins.home <= 1'b0;
    pins.index <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
endmodule
